// ===== tws_pkg.sv
/*
 * Shared constants for the terminal write sync sequencer: register map,
 * control and status field positions, reset values, state encodings and timing.
 * Assumes a 125 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package tws_pkg;

	// Clock period and the 4 us delay interval, in nanoseconds.
	localparam int unsigned TWS_CLK_NS = 8;
	localparam int unsigned TWS_DELAY_NS = 4000;
	// A least time, so it rounds up to whole cycles.
	localparam int unsigned TWS_DELAY_CYC = (TWS_DELAY_NS + TWS_CLK_NS - 1) / TWS_CLK_NS;

	// Register byte offsets.
	localparam logic [7:0] TWS_OFS_CTRL = 8'h00;
	localparam logic [7:0] TWS_OFS_STATUS = 8'h04;
	localparam logic [7:0] TWS_OFS_DATA = 8'h08;

	// Control register fields.
	localparam int unsigned TWS_CTRL_ENABLE = 0;
	localparam int unsigned TWS_CTRL_SCAN_ACTIVE = 1;
	localparam int unsigned TWS_CTRL_PEND_INT = 2;
	localparam int unsigned TWS_CTRL_SEQ_RESET = 3;
	localparam logic [3:0] TWS_CTRL_RESET = 4'h0;

	// Status register fields.
	localparam int unsigned TWS_ST_MAJOR = 0;
	localparam int unsigned TWS_ST_MINOR = 4;
	localparam int unsigned TWS_ST_AQ = 6;
	localparam int unsigned TWS_ST_BQ = 7;
	localparam int unsigned TWS_ST_IGM = 8;
	localparam int unsigned TWS_ST_CAPTURE = 9;
	localparam int unsigned TWS_ST_SCAN = 10;
	localparam int unsigned TWS_ST_TIMER = 11;
	localparam int unsigned TWS_ST_PERMIT = 12;

	// Data register fields.
	localparam int unsigned TWS_DT_A = 0;
	localparam int unsigned TWS_DT_B = 8;
	localparam int unsigned TWS_DT_SEL = 16;
	localparam int unsigned TWS_DT_STAT = 20;
	localparam int unsigned TWS_DT_TYPE = 24;

	// Buffer status bits, one-hot, weight 8 down to weight 1.
	localparam int unsigned TWS_R_WRITE_READY = 3;
	localparam int unsigned TWS_R_READ_READY = 2;
	localparam int unsigned TWS_R_BUSY = 1;
	localparam int unsigned TWS_R_NOT_READY = 0;

	// Terminal select codes from the two zone lines.
	localparam logic [3:0] TWS_SEL_ZONE_A = 4'h1;
	localparam logic [3:0] TWS_SEL_ZONE_B = 4'h2;
	localparam logic [3:0] TWS_SEL_BOTH = 4'h3;
	localparam logic [3:0] TWS_SEL_NONE = 4'h4;

	// Adapter type codes.
	localparam logic [1:0] TWS_TYPE_BAUDOT = 2'h0;
	localparam logic [1:0] TWS_TYPE_ASCII = 2'h1;
	localparam logic [1:0] TWS_TYPE_NONE = 2'h2;

	// Major and minor sequencer states.
	typedef enum logic [2:0] {
		TWS_MAJ_IDLE = 3'h0,
		TWS_MAJ_XFER = 3'h2,
		TWS_MAJ_WRITE = 3'h6
	} tws_major_e;

	typedef enum logic [1:0] {
		TWS_MIN_0 = 2'h0,
		TWS_MIN_1 = 2'h1,
		TWS_MIN_2 = 2'h2,
		TWS_MIN_3 = 2'h3
	} tws_minor_e;

endpackage : tws_pkg

// ===== tws_delay.sv
/*
 * One-shot delay timer: a start pulse runs it for a set number of cycles.
 * Assumes start is a single-cycle pulse from logic on the same clock.
 */
`timescale 1ns/1ps
module tws_delay #(
	parameter int unsigned CYCLES = 500
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic start,
	output logic running
);

	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// A restart reloads the full interval, like retriggering a monostable.
	always_comb begin
		cnt_d = cnt_q;
		if (clr) begin
			cnt_d = '0;
		end else if (start) begin
			cnt_d = LOAD;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign running = (cnt_q != '0);

endmodule : tws_delay

// ===== tws_seq.sv
/*
 * Write setup sequencer of a terminal control unit: takes the processor's
 * select character, synchronises with the addressed terminal and captures
 * buffer status and adapter type. Registers sit on an AHB-Lite slave.
 * Assumes processor and terminal pins are asynchronous to sys_clk.
 */
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module tws_seq import tws_pkg::*; #(
	parameter int unsigned DELAY_CYC = TWS_DELAY_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic sync_request_level,
	input wire logic write_request_level,
	input wire logic ignore_mark_variant_line,
	input wire logic zone_a_line,
	input wire logic zone_b_line,
	input wire logic [3:0] output_info_lines,
	input wire logic unit_ready_level,
	input wire logic terminal_char_pulse,
	input wire logic selected_interrupt_status,
	input wire logic [3:0] term_buffer_status,
	input wire logic [1:0] term_adapter_type,
	input wire logic [3:0] term_buffer_number,
	output logic term_sync_level,
	output logic term_read_request_level,
	output logic [3:0] term_buffer_out,
	output logic [3:0] terminal_select,
	output logic proc_write_ready_level,
	output logic proc_not_ready_level,
	output logic ignore_mark_flag
);

	localparam int unsigned NPIN = 18;

	// Reset release through two flip-flops.
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// Pin synchronisers; only the second stage and the edge stage are read.
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_meta_q;
	logic [NPIN-1:0] pin_q;
	logic pulse_last_q;
	assign pin_raw = {sync_request_level, write_request_level, ignore_mark_variant_line,
		zone_a_line, zone_b_line, output_info_lines, unit_ready_level,
		terminal_char_pulse, selected_interrupt_status, term_adapter_type,
		term_buffer_number};
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_meta_q <= '0;
			pin_q <= '0;
			pulse_last_q <= 1'b0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_q <= pin_meta_q;
			pulse_last_q <= pin_q[7];
		end
	end

	// Buffer status is sampled in the same cycle as the character pulse edge.
	logic [3:0] stat_meta_q;
	logic [3:0] stat_q;
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			stat_meta_q <= '0;
			stat_q <= '0;
		end else begin
			stat_meta_q <= term_buffer_status;
			stat_q <= stat_meta_q;
		end
	end

	logic s_sync;
	logic s_write;
	logic s_mv8;
	logic s_zone_a;
	logic s_zone_b;
	logic [3:0] s_info;
	logic s_ready;
	logic s_sel_int;
	logic [1:0] s_type;
	logic [3:0] s_bufnum;
	logic char_edge;
	// Bit order follows the packing of pin_raw: number [3:0], type [5:4], interrupt [6],
	// character pulse [7], and the processor and ready pins from bit 8 upwards.
	assign {s_sync, s_write, s_mv8, s_zone_a, s_zone_b, s_info, s_ready} = pin_q[NPIN-1:8];
	assign s_sel_int = pin_q[6];
	assign s_type = pin_q[5:4];
	assign s_bufnum = pin_q[3:0];
	assign char_edge = pin_q[7] & ~pulse_last_q;

	// Bus control registers.
	logic [3:0] ctrl_q;
	logic [3:0] ctrl_d;
	logic seq_clr;
	assign seq_clr = ctrl_q[TWS_CTRL_SEQ_RESET];

	// Sequencer state.
	tws_major_e major_q;
	tws_major_e major_d;
	tws_minor_e minor_q;
	tws_minor_e minor_d;
	logic [3:0] a_reg_q;
	logic [3:0] a_reg_d;
	logic [3:0] b_reg_q;
	logic [3:0] b_reg_d;
	logic [3:0] sel_q;
	logic [3:0] sel_d;
	logic [3:0] r_reg_q;
	logic [3:0] r_reg_d;
	logic [1:0] t_reg_q;
	logic [1:0] t_reg_d;
	logic a_occupied_flag;
	logic aq_d;
	logic b_occupied_flag;
	logic bq_d;
	logic ignore_mark_capture;
	logic cap_d;
	logic igm_q;
	logic igm_d;
	logic scan_flag;
	logic scan_d;
	logic a_clk;
	logic b_clk;
	logic a_delay_timer;

	// A one-shot counter stands in for the analogue delay monostable.
	tws_delay #(
		.CYCLES(DELAY_CYC)
	) u_a_delay (
		.sys_clk(sys_clk),
		.rst_n(rst_n_q),
		.clr(seq_clr),
		.start(a_clk),
		.running(a_delay_timer)
	);

	// Clock pulse enables, one cycle each, from state and synced pins.
	always_comb begin
		a_clk = 1'b0;
		b_clk = 1'b0;
		if (ctrl_q[TWS_CTRL_ENABLE] && !seq_clr) begin
			unique case (major_q)
				TWS_MAJ_IDLE: a_clk = s_sync;
				TWS_MAJ_WRITE: begin
					unique case (minor_q)
						TWS_MIN_0: begin
							b_clk = a_occupied_flag & ~a_delay_timer;
							a_clk = ~a_occupied_flag & ~b_clk & ~a_delay_timer;
						end
						TWS_MIN_1: a_clk = char_edge;
						TWS_MIN_3: a_clk = ~s_sync;
						default: a_clk = 1'b0;
					endcase
				end
				default: a_clk = 1'b0;
			endcase
		end
	end

	// Next-state logic for the sequencer registers.
	always_comb begin
		major_d = major_q;
		minor_d = minor_q;
		a_reg_d = a_reg_q;
		b_reg_d = b_reg_q;
		sel_d = sel_q;
		r_reg_d = r_reg_q;
		t_reg_d = t_reg_q;
		aq_d = a_occupied_flag;
		bq_d = b_occupied_flag;
		cap_d = ignore_mark_capture;
		igm_d = igm_q;
		scan_d = scan_flag;
		if (seq_clr) begin
			major_d = TWS_MAJ_IDLE;
			minor_d = TWS_MIN_0;
			aq_d = 1'b0;
			bq_d = 1'b0;
			scan_d = 1'b0;
			igm_d = 1'b0;
		end else if (b_clk) begin
			b_reg_d = a_reg_q;
			aq_d = 1'b0;
			igm_d = ignore_mark_capture;
			bq_d = s_ready;
		end else if (a_clk) begin
			if (major_q == TWS_MAJ_IDLE && minor_q == TWS_MIN_0) begin
				minor_d = ctrl_q[TWS_CTRL_SCAN_ACTIVE] ? TWS_MIN_3 : TWS_MIN_2;
			end else if (major_q == TWS_MAJ_IDLE) begin
				a_reg_d = s_info;
				aq_d = 1'b1;
				unique case ({s_zone_a, s_zone_b})
					2'b10: sel_d = TWS_SEL_ZONE_A;
					2'b01: sel_d = TWS_SEL_ZONE_B;
					2'b11: sel_d = TWS_SEL_BOTH;
					2'b00: sel_d = TWS_SEL_NONE;
				endcase
				cap_d = s_mv8;
				if (s_write) begin
					major_d = TWS_MAJ_WRITE;
					minor_d = TWS_MIN_0;
				end
			end else if (minor_q == TWS_MIN_0) begin
				scan_d = ctrl_q[TWS_CTRL_PEND_INT] & ~s_sel_int;
				if (b_occupied_flag) begin
					minor_d = TWS_MIN_1;
				end else begin
					minor_d = TWS_MIN_3;
					r_reg_d = 4'h1 << TWS_R_NOT_READY;
					aq_d = 1'b1;
				end
			end else if (minor_q == TWS_MIN_1) begin
				r_reg_d = stat_q;
				t_reg_d = s_type;
				a_reg_d = s_bufnum;
				aq_d = 1'b1;
				bq_d = 1'b0;
				minor_d = TWS_MIN_3;
			end else begin
				// The write transfer proper lies outside this block; the
				// sequencer parks in idle once the processor drops sync.
				major_d = TWS_MAJ_IDLE;
				minor_d = TWS_MIN_0;
				aq_d = 1'b0;
				bq_d = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			major_q <= TWS_MAJ_IDLE;
			minor_q <= TWS_MIN_0;
			a_reg_q <= '0;
			b_reg_q <= '0;
			sel_q <= '0;
			r_reg_q <= '0;
			t_reg_q <= TWS_TYPE_BAUDOT;
			a_occupied_flag <= 1'b0;
			b_occupied_flag <= 1'b0;
			ignore_mark_capture <= 1'b0;
			igm_q <= 1'b0;
			scan_flag <= 1'b0;
		end else begin
			major_q <= major_d;
			minor_q <= minor_d;
			a_reg_q <= a_reg_d;
			b_reg_q <= b_reg_d;
			sel_q <= sel_d;
			r_reg_q <= r_reg_d;
			t_reg_q <= t_reg_d;
			a_occupied_flag <= aq_d;
			b_occupied_flag <= bq_d;
			ignore_mark_capture <= cap_d;
			igm_q <= igm_d;
			scan_flag <= scan_d;
		end
	end

	// Pin outputs, registered from next state so they track it without lag.
	logic in_sync_d;
	logic write_permit;
	assign in_sync_d = (major_d == TWS_MAJ_WRITE) && (minor_d == TWS_MIN_1);
	// Idle means no status bit set; read-ready, busy and not-ready refuse the write.
	assign write_permit = ~r_reg_d[TWS_R_READ_READY] & ~r_reg_d[TWS_R_BUSY]
		& ~r_reg_d[TWS_R_NOT_READY];
	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			term_sync_level <= 1'b0;
			term_read_request_level <= 1'b0;
			term_buffer_out <= '0;
			terminal_select <= '0;
			proc_write_ready_level <= 1'b0;
			proc_not_ready_level <= 1'b0;
			ignore_mark_flag <= 1'b0;
		end else begin
			term_sync_level <= in_sync_d;
			term_read_request_level <= in_sync_d;
			term_buffer_out <= b_reg_d;
			terminal_select <= sel_d;
			proc_write_ready_level <= write_permit;
			proc_not_ready_level <= r_reg_d[TWS_R_NOT_READY];
			ignore_mark_flag <= igm_d;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero.
	logic ap_write_q;
	logic [7:0] ap_addr_q;
	logic ap_take;
	logic [31:0] rd_word;
	logic [31:0] hrdata_d;
	assign ap_take = hsel & hready & htrans[1];

	// Read data is captured at the address phase, so a read right behind a
	// write to the same register returns the value before that write.
	always_comb begin
		rd_word = '0;
		unique case (haddr[7:0])
			TWS_OFS_CTRL: rd_word[3:0] = ctrl_q;
			TWS_OFS_STATUS: begin
				rd_word[TWS_ST_MAJOR +: 3] = major_q;
				rd_word[TWS_ST_MINOR +: 2] = minor_q;
				rd_word[TWS_ST_AQ] = a_occupied_flag;
				rd_word[TWS_ST_BQ] = b_occupied_flag;
				rd_word[TWS_ST_IGM] = igm_q;
				rd_word[TWS_ST_CAPTURE] = ignore_mark_capture;
				rd_word[TWS_ST_SCAN] = scan_flag;
				rd_word[TWS_ST_TIMER] = a_delay_timer;
				rd_word[TWS_ST_PERMIT] = proc_write_ready_level;
			end
			TWS_OFS_DATA: begin
				rd_word[TWS_DT_A +: 4] = a_reg_q;
				rd_word[TWS_DT_B +: 4] = b_reg_q;
				rd_word[TWS_DT_SEL +: 4] = sel_q;
				rd_word[TWS_DT_STAT +: 4] = r_reg_q;
				rd_word[TWS_DT_TYPE +: 2] = t_reg_q;
			end
			default: rd_word = '0;
		endcase
		hrdata_d = hrdata;
		// Unmapped reads return zero rather than a stale word from an earlier read.
		if (ap_take && !hwrite) begin
			hrdata_d = (haddr[31:8] == '0) ? rd_word : '0;
		end
	end

	// Control writes; the sequencer reset bit clears itself after one cycle.
	always_comb begin
		ctrl_d = ctrl_q;
		ctrl_d[TWS_CTRL_SEQ_RESET] = 1'b0;
		if (ap_write_q && ap_addr_q == TWS_OFS_CTRL) begin
			ctrl_d = hwdata[3:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ap_write_q <= 1'b0;
			ap_addr_q <= '0;
			ctrl_q <= TWS_CTRL_RESET;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			ap_write_q <= ap_take & hwrite & (haddr[31:8] == '0) & (hsize == 3'h2);
			ap_addr_q <= haddr[7:0];
			ctrl_q <= ctrl_d;
			hrdata <= hrdata_d;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Checks on the sequencer.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n_q || seq_clr);

	a_idle_minor: assert property (a_clk && major_q == TWS_MAJ_IDLE && minor_q == TWS_MIN_0
		|=> minor_q == (ctrl_q[TWS_CTRL_SCAN_ACTIVE] ? TWS_MIN_3 : TWS_MIN_2))
		else $error("idle A-clock set wrong minor state");
	a_zone_decode: assert property (a_clk && major_q == TWS_MAJ_IDLE && minor_q != TWS_MIN_0
		&& !s_zone_a && !s_zone_b |=> sel_q == TWS_SEL_NONE && a_occupied_flag)
		else $error("no-zone select not decoded as four");
	a_enter_write: assert property (a_clk && major_q == TWS_MAJ_IDLE && minor_q != TWS_MIN_0
		&& s_write |=> major_q == TWS_MAJ_WRITE && minor_q == TWS_MIN_0)
		else $error("write request did not enter major six");
	a_bclk_delay: assert property ($rose(a_delay_timer) |-> !b_clk [*8])
		else $error("B-clock fired inside the delay interval");
	a_bclk_ready: assert property (b_clk |=> b_occupied_flag == $past(s_ready)
		&& !a_occupied_flag && ignore_mark_flag == $past(ignore_mark_capture))
		else $error("B-clock did not move flags");
	a_not_ready: assert property (a_clk && major_q == TWS_MAJ_WRITE && minor_q == TWS_MIN_0
		&& !b_occupied_flag |=> minor_q == TWS_MIN_3 && r_reg_q[TWS_R_NOT_READY])
		else $error("not-ready path did not bypass sync");
	a_sync_out: assert property (major_q == TWS_MAJ_WRITE && minor_q == TWS_MIN_1
		|-> term_sync_level && term_read_request_level && term_buffer_out == b_reg_q)
		else $error("terminal sync levels missing");
	a_capture: assert property (char_edge && major_q == TWS_MAJ_WRITE && minor_q == TWS_MIN_1
		|=> r_reg_q == $past(stat_q) && minor_q == TWS_MIN_3 && !b_occupied_flag
		##1 !term_sync_level)
		else $error("status capture or sync drop wrong");
	a_permit: assert property (r_reg_q[TWS_R_READ_READY] || r_reg_q[TWS_R_BUSY]
		|-> !proc_write_ready_level)
		else $error("write permitted on read-ready or busy buffer");

	c_write_sync: cover property (major_q == TWS_MAJ_WRITE && minor_q == TWS_MIN_1
		##[1:1000] minor_q == TWS_MIN_3);
	c_not_ready: cover property (a_clk && minor_q == TWS_MIN_0 && !b_occupied_flag
		&& major_q == TWS_MAJ_WRITE);
	c_scan: cover property ($rose(scan_flag));

endmodule : tws_seq

// ===== tws_term_model.sv
/*
 * Behavioural model of a buffered terminal unit facing the write sync sequencer.
 * Assumes the bench sets buffer status, adapter type and reply delay before each sync.
 */
`timescale 1ns/1ps
module tws_term_model (
	input wire logic sys_clk,
	input wire logic sync_in,
	input wire logic read_in,
	input wire logic [3:0] number_in,
	input wire logic [3:0] status_set,
	input wire logic [1:0] type_set,
	input wire logic [7:0] reply_dly,
	output logic char_pulse,
	output logic [3:0] status_out,
	output logic [1:0] type_out,
	output logic [3:0] number_out
);
	int activity_register;
	logic [3:0] sel_q;

	// Released lines show the inverse of their last value, so stale data never looks valid.
	initial begin
		char_pulse = 1'b0;
		status_out = 4'h0;
		type_out = 2'h0;
		number_out = 4'h0;
		activity_register = 0;
		forever begin
			@(posedge sys_clk);
			if (sync_in === 1'b1) begin
				activity_register = 1;
				sel_q = number_in;
				activity_register = (read_in !== 1'b1) ? 6 : 1;
				repeat (reply_dly) @(posedge sys_clk);
				status_out <= status_set;
				type_out <= type_set;
				number_out <= sel_q;
				char_pulse <= 1'b1;
				repeat (4) @(posedge sys_clk);
				char_pulse <= 1'b0;
				while (sync_in === 1'b1) @(posedge sys_clk);
				status_out <= ~status_set;
				type_out <= ~type_set;
				number_out <= ~sel_q;
			end
		end
	end
endmodule : tws_term_model

// ===== tws_seq_tb.sv
/*
 * Self-checking bench for the write sync sequencer: AHB-Lite master, processor pins
 * and a terminal model. Assumes a zero-wait-state slave and a short delay parameter.
 */
`timescale 1ns/1ps
module tws_seq_tb import tws_pkg::*; ;
	localparam int DLY = 10;
	logic sys_clk, nrst, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, seed, r;
	logic [1:0] htrans, tty, ty_set;
	logic [2:0] hsize;
	logic syn, wrq, var8, za, zb, urdy, cpl, sint, tsync, tread, pwr, pnr, igm;
	logic [3:0] info, tst, tnum, tbout, tsel, st_set;
	logic [7:0] rdly;
	logic [3:0] stl [5] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
	int n_errors, tests_run;

	tws_seq #(.DELAY_CYC(DLY)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.sync_request_level(syn), .write_request_level(wrq),
		.ignore_mark_variant_line(var8), .zone_a_line(za), .zone_b_line(zb),
		.output_info_lines(info), .unit_ready_level(urdy), .terminal_char_pulse(cpl),
		.selected_interrupt_status(sint), .term_buffer_status(tst),
		.term_adapter_type(tty), .term_buffer_number(tnum), .term_sync_level(tsync),
		.term_read_request_level(tread), .term_buffer_out(tbout), .terminal_select(tsel),
		.proc_write_ready_level(pwr), .proc_not_ready_level(pnr), .ignore_mark_flag(igm));

	tws_term_model i_term (.sys_clk(sys_clk), .sync_in(tsync), .read_in(tread),
		.number_in(tbout), .status_set(st_set), .type_set(ty_set), .reply_dly(rdly),
		.char_pulse(cpl), .status_out(tst), .type_out(tty), .number_out(tnum));

	// Free-running clock at 125 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic stop_test();
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One single word transfer; the address phase is held until hready is seen high.
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge sys_clk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb

	// Bounded wait for a level; returns the cycles spent.
	task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
	endtask : wait_lvl

	// One write setup with a ready or a not-ready terminal; sync is left high.
	task automatic flow(input int i, input logic ok);
		logic [31:0] x;
		logic [3:0] nb, st, sel_e;
		logic [1:0] ty;
		logic v, pend, si;
		int n;
		x = rnd();
		nb = x[3:0];
		v = x[4];
		pend = x[5];
		si = x[6];
		st = stl[x[10:8] % 5];
		ty = (x[13:12] == 2'h3) ? 2'h2 : x[13:12];
		sel_e = (i[1:0] == 2'h0) ? 4'h4 : {2'h0, i[1:0]};
		st_set <= st;
		ty_set <= ty;
		rdly <= i[0] ? 8'd40 : 8'd1;
		urdy <= ok;
		sint <= si;
		za <= i[0];
		zb <= i[1];
		info <= nb;
		var8 <= v;
		ahb(1'b1, {24'h0, TWS_OFS_CTRL}, {29'h0, pend, 2'h1}, x);
		syn <= 1'b1;
		wrq <= 1'b1;
		if (ok) begin
			wait_lvl(tsync, 1'b1, DLY + 60, n);
			chk("sync_delay", 32'h1, {31'h0, n >= DLY && n < DLY + 60});
			chk("terminal_select", {28'h0, sel_e}, {28'h0, tsel});
			chk("buffer_out", {28'h0, nb}, {28'h0, tbout});
			chk("read_request", 32'h1, {31'h0, tread});
			chk("ignore_flag", {31'h0, v}, {31'h0, igm});
			wait_lvl(tsync, 1'b0, 200, n);
			chk("sync_dropped", 32'h0, {31'h0, tsync});
			chk("write_ready", {31'h0, st == 4'h0 || st[3]}, {31'h0, pwr});
			chk("not_ready", {31'h0, st[0]}, {31'h0, pnr});
			ahb(1'b0, {24'h0, TWS_OFS_DATA}, 32'h0, x);
			chk("data_reg", {6'h0, ty, st, sel_e, 4'h0, nb, 4'h0, nb}, x);
		end else begin
			// Not-ready may still stand from the previous setup, so wait out the whole
			// sequence instead of the level; sync would have risen well inside this span.
			repeat (DLY + 30) @(posedge sys_clk);
			chk("not_ready", 32'h1, {31'h0, pnr});
			chk("sync_bypassed", 32'h0, {31'h0, tsync});
			chk("write_ready_nr", 32'h0, {31'h0, pwr});
		end
		ahb(1'b0, {24'h0, TWS_OFS_STATUS}, 32'h0, x);
		chk("status_reg", {21'h0, pend & ~si, 1'b0, v, 4'h7, 4'h6}, x & 32'h5FF);
		$display("test %0d done", i);
	endtask : flow

	// Watchdog sized well above the expected run of under a thousand cycles.
	initial begin
		#(8 * 40000);
		n_errors++;
		stop_test();
	end

	// Main sequence: reset, register checks, then write setups over all select codes.
	initial begin
		seed = 32'd68461;
		nrst = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		{syn, wrq, var8, za, zb, urdy, sint} = 7'h0;
		info = 4'h0;
		st_set = 4'h0;
		ty_set = 2'h0;
		rdly = 8'd1;
		n_errors = 0;
		tests_run = 0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		ahb(1'b0, {24'h0, TWS_OFS_STATUS}, 32'h0, r);
		chk("status_reset", 32'h0, r & 32'h5FF);
		ahb(1'b0, {24'h0, TWS_OFS_CTRL}, 32'h0, r);
		chk("ctrl_reset", {28'h0, TWS_CTRL_RESET}, r);
		// A nonzero read first, so a stale word on the unmapped read would show.
		ahb(1'b1, {24'h0, TWS_OFS_CTRL}, 32'h1, r);
		ahb(1'b0, {24'h0, TWS_OFS_CTRL}, 32'h0, r);
		chk("ctrl_write", 32'h1, r);
		ahb(1'b1, 32'h100, 32'hFFFFFFFF, r);
		ahb(1'b0, 32'h100, 32'h0, r);
		chk("unmapped", 32'h0, r);
		chk("okay_resp", 32'h0, {31'h0, hresp});
		for (int i = 0; i < 8; i++) begin
			flow(i, i != 5);
			if (i == 7) begin
				// Sequencer reset with enable off, so sync still high cannot restart it.
				ahb(1'b1, {24'h0, TWS_OFS_CTRL}, 32'h8, r);
				ahb(1'b0, {24'h0, TWS_OFS_STATUS}, 32'h0, r);
				chk("seq_reset", 32'h0, r & 32'h5FF);
			end
			syn <= 1'b0;
			wrq <= 1'b0;
			repeat (8) @(posedge sys_clk);
		end
		stop_test();
	end
endmodule : tws_seq_tb
